// >>> shared/fpct_pkg.sv
// Constants, states and trap locations for the trap sequencer.
// Assumes a single clk_sys domain; all CPU and channel time pulses
// arrive as one-cycle strobes generated on that same clock.
//
// Contract
// - Overflow is P only; underflow is P and Q
// - FP trap trigger sets at next I2
// - FP trap served before every other trap
// - FP trap blocks program register, forces store-and-trap
// - Address cleared at I6, location zero accessed
// - E0 stores PC minus one, clears high bits
// - FP code on bus 14-17, decrement/address stores
// - E5 sets PC to octal 10, address at I6
// - FP trap and FP triggers clear at I1
// - Channel trap stores at even, executes odd location
// - Channel code bits 17, 16, 15 stored
// - Unenabled channel conditions held until enabled or reset
// - Channel traps wait behind pending FP trap
// - Select, enable, execute, restore postpone one instruction
// - Serviced trap clears restore, blocks further requests
// - Non-transfer at odd location resumes interrupted program
// - Enable word maps tape-check and control/EOF enables
// - Enable instruction clears all enables at channel E0
// - Enables load at channel E8, demand waits
// - Restore sets at L1, inhibits next instruction
// - Request only when enabled and restore set
// - FP code bits divide, overflow, accumulator, quotient
// - Odd location via forced low address bit
package fpct_pkg;
   localparam int NCH = 8; // Channels A..H
   localparam int PC_W = 15; // Address field width
   localparam int WORD_W = 36; // Memory word width
   localparam int IDX_W = 3; // Channel index width
   // Word index = 35 - printed bit position
   localparam int EN_TAPE_LSB = 18; // Printed bit 17 for channel A
   localparam int EN_WORD_LSB = 0; // Printed bit 35 for channel A
   localparam logic [PC_W-1:0] LOC_ZERO = 15'h0000;
   localparam logic [PC_W-1:0] FP_TRAP_LOC = 15'h0008; // Octal 10
   localparam logic [PC_W-1:0] CH_TRAP_BASE = 15'h000a; // Octal 12
   localparam logic [PC_W-1:0] ODD_BIT = 15'h0001; // Bus bit 17
   localparam logic [PC_W-1:0] PC_MINUS_ONE = 15'h7fff; // All ones operand
   localparam logic [3:0] CODE_NONE = 4'h0;
   // Sequencer states, Gray along each trap path
   typedef enum logic [2:0] {
      FPCT_IDLE = 3'h0,
      FPCT_FP_E = 3'h1,
      FPCT_FP_NX = 3'h3,
      FPCT_CH_E = 3'h2,
      FPCT_CH_NX = 3'h6
   } fpct_state_e;
endpackage

// >>> shared/fpct_link_if.sv
// Carrier between the sequencer and its detector and channel modules.
// Assumes all three modules share clk_sys.
interface fpct_link_if;
   // Floating-point detector group
   logic fp_clear; // Clear FP triggers
   logic fp_pend; // FP trap condition pending
   logic [14:17] fp_code; // Identification bits, printed order
   // Channel group
   logic restore; // Restore trigger level
   logic en_clear; // Clear all enables
   logic en_load; // Load enables from operand
   logic [35:0] en_word; // Enable operand word
   logic service; // Granted channel serviced
   logic [2:0] svc_idx; // Channel being serviced
   logic req_any; // Some channel requests
   logic [2:0] grant_idx; // Winning channel
   logic [2:0] grant_bits; // Control-word, tape-check, end-of-file
   modport seq (output fp_clear, restore, en_clear, en_load, en_word,
      service, svc_idx, input fp_pend, fp_code, req_any, grant_idx, grant_bits);
   modport fp (input fp_clear, output fp_pend, fp_code);
   modport ch (input restore, en_clear, en_load, en_word, service, svc_idx,
      output req_any, grant_idx, grant_bits);
endinterface

// >>> design/fpct_fp_detect.sv
// Floating-point overflow and underflow detector with trap triggers.
// Assumes adder position bits are valid when fp_done strobes.
module fpct_fp_detect (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Adder observation
   input wire logic fp_done,
   input wire logic add_p,
   input wire logic add_q,
   input wire logic on_quot,
   input wire logic divide,
   // Sequencer side
   fpct_link_if.fp lk
);
   logic ovf; // Overflow seen
   logic unf; // Underflow seen

   // Classify adder overflow positions
   always_comb begin
      ovf = add_p & ~add_q;
      unf = add_p & add_q;
   end

   // Sticky triggers; a new event beats the clear
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         lk.fp_pend <= 1'b0;
         lk.fp_code <= fpct_pkg::CODE_NONE;
      end else if (fp_done && (ovf || unf)) begin
         lk.fp_pend <= 1'b1;
         lk.fp_code[14] <= divide;
         lk.fp_code[15] <= ovf;
         lk.fp_code[16] <= ~on_quot;
         lk.fp_code[17] <= on_quot;
      end else if (lk.fp_clear) begin
         lk.fp_pend <= 1'b0;
         lk.fp_code <= fpct_pkg::CODE_NONE;
      end
   end
endmodule

// >>> design/fpct_chan_pend.sv
// Per-channel held trap conditions, enables and fixed-order grant.
// Assumes channel condition strobes are on clk_sys.
module fpct_chan_pend #(
   parameter int NCH = fpct_pkg::NCH
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Channel conditions, one bit per channel
   input wire logic [NCH-1:0] cwt_evt,
   input wire logic [NCH-1:0] tape_evt,
   input wire logic [NCH-1:0] eof_evt,
   input wire logic [NCH-1:0] cond_reset,
   // Sequencer side
   fpct_link_if.ch lk
);
   logic [NCH-1:0] p_cwt, p_tape, p_eof; // Held conditions
   logic [NCH-1:0] en_tape, en_ce; // Enable triggers
   logic [NCH-1:0] req; // Per-channel request

   if (NCH < 1 || NCH > fpct_pkg::NCH) begin
      $error("fpct_chan_pend: NCH out of range");
   end

   for (genvar i = 0; i < NCH; i++) begin : g_ch
      logic svc; // This channel serviced now
      assign svc = lk.service && (lk.svc_idx == 3'(i));
      // Conditions are held regardless of enables; set beats clear
      always_ff @(posedge clk_sys) begin
         if (!rst_n) begin
            p_cwt[i] <= 1'b0;
            p_tape[i] <= 1'b0;
            p_eof[i] <= 1'b0;
         end else begin
            p_cwt[i] <= cwt_evt[i] | (p_cwt[i] & ~cond_reset[i] & ~(svc & en_ce[i]));
            p_tape[i] <= tape_evt[i] | (p_tape[i] & ~cond_reset[i] & ~(svc & en_tape[i]));
            p_eof[i] <= eof_evt[i] | (p_eof[i] & ~cond_reset[i] & ~(svc & en_ce[i]));
         end
      end
      // Enable triggers: cleared at channel E0, loaded at E8
      always_ff @(posedge clk_sys) begin
         if (!rst_n) begin
            en_tape[i] <= 1'b0;
            en_ce[i] <= 1'b0;
         end else if (lk.en_clear) begin
            en_tape[i] <= 1'b0;
            en_ce[i] <= 1'b0;
         end else if (lk.en_load) begin
            en_tape[i] <= lk.en_word[fpct_pkg::EN_TAPE_LSB + i];
            en_ce[i] <= lk.en_word[fpct_pkg::EN_WORD_LSB + i];
         end
      end
      assign req[i] = lk.restore & ((en_ce[i] & (p_cwt[i] | p_eof[i]))
         | (en_tape[i] & p_tape[i]));
   end

   // Fixed order grant, channel A wins
   always_comb begin
      lk.req_any = |req;
      lk.grant_idx = 3'h0;
      lk.grant_bits = 3'h0;
      for (int k = NCH - 1; k >= 0; k--) begin
         if (req[k]) begin
            lk.grant_idx = k[2:0];
            lk.grant_bits = {p_cwt[k] & en_ce[k], p_tape[k] & en_tape[k],
               p_eof[k] & en_ce[k]};
         end
      end
   end
endmodule

// >>> design/fpct_trap_seq.sv
// Trap sequencer for floating-point and data channel traps.
// Assumes I, E, L and channel time pulses are one-cycle strobes on
// clk_sys, and instruction decode levels hold through the instruction.
module fpct_trap_seq (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // CPU time pulses
   input wire logic t_i1,
   input wire logic t_i2,
   input wire logic t_i3,
   input wire logic t_i4,
   input wire logic t_i6,
   input wire logic t_e0,
   input wire logic t_e3,
   input wire logic t_e5,
   input wire logic t_l1,
   // Channel time pulses
   input wire logic t_ch_e0,
   input wire logic t_ch_e8,
   // Instruction decode levels
   input wire logic instr_select,
   input wire logic instr_enable,
   input wire logic instr_execute,
   input wire logic instr_restore,
   // Floating-point adder observation
   input wire logic fp_done,
   input wire logic add_p,
   input wire logic add_q,
   input wire logic fp_on_quot,
   input wire logic fp_divide,
   // Channel conditions
   input wire logic [fpct_pkg::NCH-1:0] ch_cwt,
   input wire logic [fpct_pkg::NCH-1:0] ch_tape,
   input wire logic [fpct_pkg::NCH-1:0] ch_eof,
   input wire logic [fpct_pkg::NCH-1:0] ch_cond_reset,
   // Data path inputs
   input wire logic [fpct_pkg::PC_W-1:0] pc_in,
   input wire logic [35:0] memory_data_bus_out,
   // Program register and sequence control
   output logic block_pr_load,
   output logic store_location_and_trap,
   output logic pc_hold,
   output logic cpu_proceed_trigger_set,
   // Memory address and program counter
   output logic addr_load,
   output logic [fpct_pkg::PC_W-1:0] memory_address_reg,
   output logic pc_load,
   output logic [fpct_pkg::PC_W-1:0] pc_value,
   // Storage register and bus
   output logic sr_load,
   output logic [fpct_pkg::PC_W-1:0] sr_addr,
   output logic sr_clear_high,
   output logic store_decrement,
   output logic store_address,
   output logic [14:17] store_bus_code,
   // Status
   output logic fp_trap_trig,
   output logic ch_trap_trig,
   output logic restore_trig
);
   fpct_link_if lk ();

   fpct_pkg::fpct_state_e st; // Sequencer state
   logic postpone_prev; // Previous instruction postpones traps
   logic postpones_now; // Current instruction postpones traps
   logic [2:0] ch_idx; // Channel being trapped
   logic [2:0] ch_bits; // Latched channel code
   logic [fpct_pkg::PC_W-1:0] even_loc; // Channel even location

   // Floating-point detector
   fpct_fp_detect u_fp (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .fp_done(fp_done),
      .add_p(add_p),
      .add_q(add_q),
      .on_quot(fp_on_quot),
      .divide(fp_divide),
      .lk(lk.fp)
   );

   // Channel conditions and enables
   fpct_chan_pend #(.NCH(fpct_pkg::NCH)) u_ch (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .cwt_evt(ch_cwt),
      .tape_evt(ch_tape),
      .eof_evt(ch_eof),
      .cond_reset(ch_cond_reset),
      .lk(lk.ch)
   );

   // Instructions during which channel demands wait
   assign postpones_now = instr_select | instr_enable | instr_execute
      | instr_restore;
   // Even location: base plus twice the channel number
   assign even_loc = fpct_pkg::CH_TRAP_BASE
      + fpct_pkg::PC_W'({ch_idx, 1'b0});

   // Enable, restore and service strobes into channel module, FP clear into detector
   always_comb begin
      lk.en_clear = t_ch_e0 & instr_enable;
      lk.en_load = t_ch_e8 & instr_enable;
      lk.en_word = memory_data_bus_out;
      lk.restore = restore_trig;
      lk.service = (st == fpct_pkg::FPCT_CH_E) && t_e0;
      lk.svc_idx = ch_idx;
      lk.fp_clear = (st == fpct_pkg::FPCT_FP_NX) && t_i1;
   end

   // Postponement memory, sampled at each I3
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         postpone_prev <= 1'b0;
      end else if (t_i3) begin
         // Covers the instruction following enable or restore
         postpone_prev <= instr_enable | instr_restore;
      end
   end

   // Restore trigger
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         restore_trig <= 1'b0;
      end else if (t_l1 && (instr_restore || instr_enable)) begin
         restore_trig <= 1'b1;
      end else if (st == fpct_pkg::FPCT_CH_E && t_e3) begin
         restore_trig <= 1'b0;
      end
   end

   // Floating-point trap trigger
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         fp_trap_trig <= 1'b0;
      end else if (t_i2 && lk.fp_pend && st == fpct_pkg::FPCT_IDLE) begin
         fp_trap_trig <= 1'b1;
      end else if (lk.fp_clear) begin
         fp_trap_trig <= 1'b0;
      end
   end

   // Channel trap trigger and latched grant
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ch_trap_trig <= 1'b0;
         ch_idx <= 3'h0;
         ch_bits <= 3'h0;
      end else if (t_i3 && lk.req_any && st == fpct_pkg::FPCT_IDLE
            && !fp_trap_trig && !lk.fp_pend
            && !postpones_now && !postpone_prev) begin
         ch_trap_trig <= 1'b1;
         ch_idx <= lk.grant_idx;
         ch_bits <= lk.grant_bits;
      end else if (st == fpct_pkg::FPCT_CH_NX && t_i2) begin
         ch_trap_trig <= 1'b0;
      end
   end

   // Sequencer state
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         st <= fpct_pkg::FPCT_IDLE;
      end else begin
         case (st)
            fpct_pkg::FPCT_IDLE: begin
               // FP wins even when both triggers stand
               if (t_i4 && fp_trap_trig) begin
                  st <= fpct_pkg::FPCT_FP_E;
               end else if (t_i4 && ch_trap_trig) begin
                  st <= fpct_pkg::FPCT_CH_E;
               end
            end
            fpct_pkg::FPCT_FP_E: begin
               if (t_e5) begin
                  st <= fpct_pkg::FPCT_FP_NX;
               end
            end
            fpct_pkg::FPCT_FP_NX: begin
               if (t_i1) begin
                  st <= fpct_pkg::FPCT_IDLE;
               end
            end
            fpct_pkg::FPCT_CH_E: begin
               if (t_e5) begin
                  st <= fpct_pkg::FPCT_CH_NX;
               end
            end
            fpct_pkg::FPCT_CH_NX: begin
               if (t_i2) begin
                  st <= fpct_pkg::FPCT_IDLE;
               end
            end
            default: begin
               st <= fpct_pkg::FPCT_IDLE;
            end
         endcase
      end
   end

   // Fetch override at I4, PC hold after channel trap
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         block_pr_load <= 1'b0;
         store_location_and_trap <= 1'b0;
         pc_hold <= 1'b0;
      end else begin
         block_pr_load <= t_i4 && st == fpct_pkg::FPCT_IDLE
            && (fp_trap_trig || ch_trap_trig);
         store_location_and_trap <= t_i4 && st == fpct_pkg::FPCT_IDLE
            && (fp_trap_trig || ch_trap_trig);
         // PC left at stored value, so a non-transfer resumes there
         pc_hold <= st == fpct_pkg::FPCT_CH_NX && t_i2;
      end
   end

   // Go trigger set when enable operand has been taken
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         cpu_proceed_trigger_set <= 1'b0;
      end else begin
         cpu_proceed_trigger_set <= t_ch_e8 && instr_enable;
      end
   end

   // Memory address register steering
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         addr_load <= 1'b0;
         memory_address_reg <= fpct_pkg::LOC_ZERO;
      end else begin
         addr_load <= 1'b0;
         if (t_i4 && st == fpct_pkg::FPCT_IDLE && fp_trap_trig) begin
            // Address register cleared, zero presented at I6
            memory_address_reg <= fpct_pkg::LOC_ZERO;
         end
         case (st)
            fpct_pkg::FPCT_FP_E: begin
               if (t_i6) begin
                  addr_load <= 1'b1;
                  memory_address_reg <= fpct_pkg::LOC_ZERO;
               end
            end
            fpct_pkg::FPCT_FP_NX: begin
               if (t_i6) begin
                  addr_load <= 1'b1;
                  memory_address_reg <= fpct_pkg::FP_TRAP_LOC;
               end
            end
            fpct_pkg::FPCT_CH_E: begin
               if (t_i6) begin
                  addr_load <= 1'b1;
                  memory_address_reg <= even_loc;
               end
            end
            fpct_pkg::FPCT_CH_NX: begin
               if (t_i6) begin
                  addr_load <= 1'b1;
                  memory_address_reg <= even_loc | fpct_pkg::ODD_BIT;
               end
            end
            default: begin
               addr_load <= 1'b0;
            end
         endcase
      end
   end

   // Program counter forced to octal 10 at E5
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         pc_load <= 1'b0;
         pc_value <= fpct_pkg::LOC_ZERO;
      end else begin
         pc_load <= st == fpct_pkg::FPCT_FP_E && t_e5;
         if (st == fpct_pkg::FPCT_FP_E && t_e5) begin
            pc_value <= fpct_pkg::FP_TRAP_LOC;
         end
      end
   end

   // Storage register and store lines at E0
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         sr_load <= 1'b0;
         sr_addr <= fpct_pkg::LOC_ZERO;
         sr_clear_high <= 1'b0;
         store_decrement <= 1'b0;
         store_address <= 1'b0;
      end else begin
         sr_load <= 1'b0;
         sr_clear_high <= 1'b0;
         if (t_e0 && (st == fpct_pkg::FPCT_FP_E || st == fpct_pkg::FPCT_CH_E)) begin
            sr_load <= 1'b1;
            // Index adders with all ones: wraps like the hardware
            sr_addr <= pc_in + fpct_pkg::PC_MINUS_ONE;
            sr_clear_high <= 1'b1;
            store_decrement <= 1'b1;
            store_address <= 1'b1;
         end else if (st == fpct_pkg::FPCT_IDLE) begin
            store_decrement <= 1'b0;
            store_address <= 1'b0;
         end
      end
   end

   // Identification bits on the storage bus
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         store_bus_code <= fpct_pkg::CODE_NONE;
      end else if (t_e0 && st == fpct_pkg::FPCT_FP_E) begin
         store_bus_code <= lk.fp_code;
      end else if (t_e0 && st == fpct_pkg::FPCT_CH_E) begin
         // Bit 17 control word, 16 tape check, 15 end of file
         store_bus_code <= {1'b0, ch_bits[0], ch_bits[1], ch_bits[2]};
      end else if (st == fpct_pkg::FPCT_IDLE) begin
         store_bus_code <= fpct_pkg::CODE_NONE;
      end
   end
endmodule

// >>> sim/fpct_trap_seq_assertions.sv
// Concurrent checks on the trap sequencer top ports.
// Assumes one clk_sys domain with synchronous active-low rst_n.
module fpct_trap_seq_assertions (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Time pulses and decode
   input wire logic t_i1,
   input wire logic t_i2,
   input wire logic t_i3,
   input wire logic t_i4,
   input wire logic t_l1,
   input wire logic t_ch_e8,
   input wire logic instr_enable,
   input wire logic instr_restore,
   input wire logic [fpct_pkg::PC_W-1:0] pc_in,
   // Observed outputs
   input wire logic block_pr_load,
   input wire logic store_location_and_trap,
   input wire logic cpu_proceed_trigger_set,
   input wire logic addr_load,
   input wire logic [fpct_pkg::PC_W-1:0] memory_address_reg,
   input wire logic sr_load,
   input wire logic [fpct_pkg::PC_W-1:0] sr_addr,
   input wire logic sr_clear_high,
   input wire logic store_decrement,
   input wire logic store_address,
   input wire logic [14:17] store_bus_code,
   input wire logic fp_trap_trig,
   input wire logic ch_trap_trig,
   input wire logic restore_trig
);
   // One domain
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   // FP store step
   sequence s_fp_store;
      sr_load && fp_trap_trig;
   endsequence
   // Start of a channel trap
   sequence s_ch_rise;
      $rose(ch_trap_trig);
   endsequence
   property p_fp_set;
      $rose(fp_trap_trig) |-> $past(t_i2);
   endproperty
   property p_block;
      block_pr_load |-> store_location_and_trap && $past(t_i4);
   endproperty
   property p_zero;
      addr_load && fp_trap_trig && !store_decrement |-> memory_address_reg == 15'h0000;
   endproperty
   property p_sr;
      sr_load |-> sr_clear_high && sr_addr == $past(pc_in) - 15'h0001;
   endproperty
   property p_fp_code;
      s_fp_store |-> store_decrement && store_address && $onehot(store_bus_code[16:17]);
   endproperty
   property p_loc8;
      addr_load && fp_trap_trig && store_decrement |-> memory_address_reg == 15'h0008;
   endproperty
   property p_fp_clr;
      $fell(fp_trap_trig) |-> $past(t_i1);
   endproperty
   property p_ch_go;
      s_ch_rise |-> $past(t_i3) && $past(restore_trig) && !fp_trap_trig;
   endproperty
   property p_odd;
      addr_load && ch_trap_trig |-> memory_address_reg[0] == !restore_trig;
   endproperty
   property p_rst_off;
      $fell(restore_trig) |-> ch_trap_trig;
   endproperty
   property p_proceed;
      cpu_proceed_trigger_set |-> $past(t_ch_e8 && instr_enable);
   endproperty
   property p_rst_on;
      $rose(restore_trig) |-> $past(t_l1 && (instr_enable || instr_restore));
   endproperty
   a_fp_set: assert property (p_fp_set) else $error("fp trigger rose off i2");
   a_block: assert property (p_block) else $error("load block off i4");
   a_zero: assert property (p_zero) else $error("first address not zero");
   a_sr: assert property (p_sr) else $error("stored pc wrong");
   a_fp_code: assert property (p_fp_code) else $error("fp store lines wrong");
   a_loc8: assert property (p_loc8) else $error("fp trap address wrong");
   a_fp_clr: assert property (p_fp_clr) else $error("fp trigger fell off i1");
   a_ch_go: assert property (p_ch_go) else $error("bad channel start");
   a_odd: assert property (p_odd) else $error("channel parity wrong");
   a_rst_off: assert property (p_rst_off) else $error("restore fell outside trap");
   a_proceed: assert property (p_proceed) else $error("proceed set off e8");
   a_rst_on: assert property (p_rst_on) else $error("restore set off l1");
endmodule

bind fpct_trap_seq fpct_trap_seq_assertions i_chk (.clk_sys, .rst_n, .t_i1, .t_i2, .t_i3,
   .t_i4, .t_l1, .t_ch_e8, .instr_enable, .instr_restore, .pc_in, .block_pr_load,
   .store_location_and_trap, .cpu_proceed_trigger_set, .addr_load, .memory_address_reg,
   .sr_load, .sr_addr, .sr_clear_high, .store_decrement, .store_address, .store_bus_code,
   .fp_trap_trig, .ch_trap_trig, .restore_trig);

// >>> sim/fpct_chan_model.sv
// Behavioural data channels raising trap conditions.
// Assumes the bench calls its task; pulses change at falling edges.
module fpct_chan_model (
   // Clock
   input wire logic clk_sys,
   // Condition pulses, bit 0 is channel A
   output logic [fpct_pkg::NCH-1:0] ch_cwt,
   output logic [fpct_pkg::NCH-1:0] ch_tape,
   output logic [fpct_pkg::NCH-1:0] ch_eof,
   output logic [fpct_pkg::NCH-1:0] ch_cond_reset
);
   timeunit 1ns;
   timeprecision 1ps;
   // Quiet channels until told otherwise
   initial begin
      ch_cwt = '0;
      ch_tape = '0;
      ch_eof = '0;
      ch_cond_reset = '0;
   end
   // One-cycle report; kind 0 control word, 1 tape check, 2 end of file, 3 reset
   task automatic report(input int ch, input int kind);
      @(negedge clk_sys);
      case (kind)
         0: ch_cwt[ch] = 1'b1;
         1: ch_tape[ch] = 1'b1;
         2: ch_eof[ch] = 1'b1;
         default: ch_cond_reset[ch] = 1'b1;
      endcase
      @(negedge clk_sys);
      {ch_cwt, ch_tape, ch_eof, ch_cond_reset} = '0;
   endtask
endmodule

// >>> sim/fpct_trap_seq_test.sv
// Self-checking bench for the trap sequencer.
// Assumes the channel model and checker.
module fpct_trap_seq_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0; // 50 MHz
   logic rst_n = 1'b0;
   logic [10:0] tp = '0; // i1 i2 i3 i4 i6 e0 e3 e5 l1 ch_e0 ch_e8
   logic [3:0] dec = '0; // Select, enable, execute, restore
   logic fp_done = 1'b0;
   logic [3:0] fpin = '0; // P, Q, quotient side, divide
   logic [14:0] pc_in = 15'h1234;
   logic [35:0] word = '0;
   logic [7:0] cwt, tape, eof, crst;
   logic blk, slt, pc_hold, proceed, ald, pc_load, sr_load, clr_hi;
   logic st_dec, st_addr, fp_trig, ch_trig, rst_trig;
   logic [14:0] ma, pc_value, sr_addr;
   logic [14:17] code;
   int num_errors = 0;
   int comparisons = 0;
   always #10 clk_sys = ~clk_sys;
   fpct_chan_model i_chan (.clk_sys, .ch_cwt(cwt), .ch_tape(tape), .ch_eof(eof),
      .ch_cond_reset(crst));
   fpct_trap_seq i_dut (.clk_sys, .rst_n, .t_i1(tp[0]), .t_i2(tp[1]),
      .t_i3(tp[2]), .t_i4(tp[3]), .t_i6(tp[4]), .t_e0(tp[5]), .t_e3(tp[6]), .t_e5(tp[7]),
      .t_l1(tp[8]), .t_ch_e0(tp[9]), .t_ch_e8(tp[10]), .instr_select(dec[3]),
      .instr_enable(dec[2]), .instr_execute(dec[1]), .instr_restore(dec[0]),
      .fp_done, .add_p(fpin[3]), .add_q(fpin[2]), .fp_on_quot(fpin[1]),
      .fp_divide(fpin[0]), .ch_cwt(cwt), .ch_tape(tape), .ch_eof(eof), .ch_cond_reset(crst),
      .pc_in, .memory_data_bus_out(word), .block_pr_load(blk),
      .store_location_and_trap(slt), .pc_hold, .cpu_proceed_trigger_set(proceed),
      .addr_load(ald), .memory_address_reg(ma), .pc_load, .pc_value,
      .sr_load, .sr_addr, .sr_clear_high(clr_hi), .store_decrement(st_dec),
      .store_address(st_addr), .store_bus_code(code), .fp_trap_trig(fp_trig),
      .ch_trap_trig(ch_trig), .restore_trig(rst_trig));
   // Compare and count
   task automatic chk(input string what, input logic [35:0] seen, input logic [35:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Totals, verdict and end of run
   task automatic print_verdict();
      $display("comparisons %0d errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // One-cycle time pulse
   task automatic tick(input int k);
      @(negedge clk_sys);
      tp[k] = 1'b1;
      @(negedge clk_sys);
      tp[k] = 1'b0;
   endtask
   // New instruction: decode levels, then its I1
   task automatic ins(input logic [3:0] d);
      @(negedge clk_sys);
      dec = d;
      tick(0);
   endtask
   // End of a floating-point instruction with adder bits
   task automatic fpdone(input logic [3:0] f);
      @(negedge clk_sys);
      fpin = f;
      fp_done = 1'b1;
      @(negedge clk_sys);
      fp_done = 1'b0;
   endtask
   // Whole FP trap; its I3 must not start a channel trap
   task automatic fpwalk(input logic [3:0] f, input logic [3:0] c);
      fpdone(f);
      tick(1);
      chk("fp trigger", fp_trig, 1);
      tick(2);
      chk("ch held", ch_trig, 0);
      tick(3);
      chk("load blocked", {blk, slt}, 2'b11);
      tick(4);
      chk("zero address", {ald, ma}, {1'b1, 15'h0000});
      tick(5);
      chk("stored pc", {sr_load, clr_hi, sr_addr}, {2'b11, pc_in - 15'h0001});
      chk("fp code", {st_dec, st_addr, code}, {2'b11, c});
      tick(7);
      chk("pc octal 10", {pc_load, pc_value}, {1'b1, fpct_pkg::FP_TRAP_LOC});
      tick(4);
      chk("trap address", {ald, ma}, {1'b1, fpct_pkg::FP_TRAP_LOC});
      tick(0);
      @(negedge clk_sys);
      chk("fp trigger off", {fp_trig, st_dec, code}, 0);
   endtask
   // Whole channel trap, granted at its I3
   task automatic chwalk(input int ch, input logic [3:0] c);
      logic [14:0] even;
      even = fpct_pkg::CH_TRAP_BASE + 15'(2 * ch);
      tick(2);
      chk("channel trigger", ch_trig, 1);
      tick(3);
      chk("load blocked", {blk, slt}, 2'b11);
      tick(4);
      chk("even address", {ald, ma}, {1'b1, even});
      tick(5);
      chk("channel word", {sr_addr, st_dec, st_addr, code}, {pc_in - 15'h0001, 2'b11, c});
      tick(6);
      chk("restore off", rst_trig, 0);
      tick(7);
      tick(4);
      chk("odd address", {ald, ma}, {1'b1, even | 15'h0001});
      tick(1);
      chk("resume", {ch_trig, pc_hold}, 2'b01);
   endtask
   // Enable instruction: L1, channel E0, channel E8
   task automatic enable(input logic [35:0] w);
      word = w;
      ins(4'h4);
      tick(2);
      chk("no trap in enable", ch_trig, 0);
      tick(8);
      tick(9);
      tick(10);
      chk("proceed and restore", {proceed, rst_trig}, 2'b11);
   endtask
   // Instruction up to I3, no channel trap
   task automatic quiet(input logic [3:0] d);
      ins(d);
      tick(2);
      chk("no channel trap", ch_trig, 0);
   endtask
   // Hang guard
   initial begin
      #100us;
      num_errors++;
      print_verdict();
   end
   // Main sequence
   initial begin
      repeat (2) @(negedge clk_sys);
      rst_n = 1'b1;
      chk("reset state", {fp_trig, ch_trig, rst_trig, ma}, 0);
      i_chan.report(0, 0);
      i_chan.report(2, 1);
      i_chan.report(7, 2);
      quiet(4'h0);
      enable(36'h000100080);
      quiet(4'h0);
      quiet(4'h8);
      quiet(4'h2);
      ins(4'h0);
      chwalk(2, 4'b0010);
      quiet(4'h0);
      quiet(4'h1);
      tick(8);
      chk("restore set", rst_trig, 1);
      quiet(4'h0);
      ins(4'h0);
      fpwalk(4'b1001, 4'b1110);
      chwalk(7, 4'b0100);
      fpdone(4'b0100);
      tick(1);
      chk("no fp trap", fp_trig, 0);
      fpwalk(4'b1110, 4'b0001);
      i_chan.report(0, 3);
      enable(36'h000000001);
      quiet(4'h0);
      quiet(4'h0);
      i_chan.report(0, 0);
      i_chan.report(2, 1);
      ins(4'h0);
      chwalk(0, 4'b0001);
      quiet(4'h1);
      tick(8);
      quiet(4'h0);
      quiet(4'h0);
      print_verdict();
   end
endmodule
